// ==== pwm_bit_serial_link_pkg.sv ====
// Shared constants for the pulse-width-coded single-wire link: timing, frame layout,
// register offsets and field positions of the slave-node assist.
// Assumes one 25 MHz core clock at both ends and an open-drain line joined by the interface.
// Functional notes
// - Low time gives bit type: sync, zero, one.
// - Master holds line low for the bit's coded low time only.
// - Master starts every bit period pulling low.
// - Slave pulls low before sync time, releases later.
// - Bit-serial mode only when control bit 6 set.
// - Control bit 8 enables rising-edge break interrupt.
// - Break timer clears on fall, stops on rise.
// - Break timer counts low-power oscillator periods.
// - Sync timer captured on every falling edge.
// - Sync timer runs freely at fast rate.
// - Compare match sets status bit 3, interrupts.
// - Transmit: drive low, compare equals capture plus width.
// - Compare interrupt ends transmitted pulse, releases line.
// - Start enable bit 3: falling edge interrupts, wakes.
// - 1200 bit/s nominal, 19-bit frames.
// - Pause, dir, address, register, parity, data, parity, ack.
// - Odd parities; the code sends even parity, each parity bit the XOR of its bits; acknowledge zero means success.
package pwm_bit_serial_link_pkg;

	// Clock rates
	localparam int CLK_HZ = 25_000_000; // Core clock
	localparam int FAST_HZ = 5_000_000; // Sync timer rate
	localparam int LP_HZ = 131_000; // Low-power oscillator rate
	localparam int BIT_RATE = 1200; // Nominal bits per second
	localparam int FAST_DIV = CLK_HZ / FAST_HZ; // Core cycles per fast tick
	localparam int LP_DIV = CLK_HZ / LP_HZ; // Core cycles per low-power tick
	localparam int BIT_CYCLES = CLK_HZ / BIT_RATE; // Core cycles per bit period

	// Low times in sixteenths of a bit period
	localparam int SYNC_16THS = 2; // Sync nominal
	localparam int ZERO_16THS = 6; // Zero nominal
	localparam int ONE_16THS = 12; // One nominal
	localparam int SZ_MID_16THS = 4; // Midway sync and zero
	localparam int ZO_MID_16THS = 9; // Midway zero and one

	// Break-timer thresholds in low-power periods for receive classification
	localparam int BIT_LP = LP_HZ / BIT_RATE; // Low-power ticks per bit
	localparam logic [15:0] BRK_SZ_THRESH = 16'(BIT_LP * SZ_MID_16THS / 16); // Sync below
	localparam logic [15:0] BRK_ZO_THRESH = 16'(BIT_LP * ZO_MID_16THS / 16); // One at or above

	// Frame layout
	localparam int PAUSE_BITS = 3; // Leading sync pulses
	localparam int FRAME_BITS = 19; // Dir through ack
	localparam int TOTAL_BITS = PAUSE_BITS + FRAME_BITS; // Periods per frame
	localparam int FI_DATA = 9; // Frame index of first data bit
	localparam int FI_ACK = 18; // Frame index of acknowledge

	// Register offsets (byte addresses)
	localparam logic [7:0] SYNC_CONTROL_OFS = 8'h00;
	localparam logic [7:0] SYNC_STATUS_OFS = 8'h04;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h08;
	localparam logic [7:0] BREAK_WIDTH_OFS = 8'h0C;
	localparam logic [7:0] SYNC_TIMER_OFS = 8'h10;
	localparam logic [7:0] EDGE_CAPTURE_OFS = 8'h14;
	localparam logic [7:0] PULSE_COMPARE_OFS = 8'h18;
	localparam logic [7:0] LINE_DRIVE_OFS = 8'h1C;

	// Control field positions
	localparam int CTL_START_EN = 3; // Start-condition interrupt enable
	localparam int CTL_CMP_EN = 5; // Compare interrupt enable
	localparam int CTL_MODE = 6; // Bit-serial mode select
	localparam int CTL_RISE_EN = 8; // Rising-edge break interrupt enable

	// Status field positions
	localparam int ST_RISE = 0; // Break timer stopped on rising edge
	localparam int ST_START = 1; // Start condition seen
	localparam int ST_CMP = 3; // Compare match

	// Reset values
	localparam logic [15:0] CTL_RESET = 16'h0000;
	localparam logic [15:0] TIMER_RESET = 16'h0000;

endpackage

// ==== pwm_link_if.sv ====
// Open-drain single-wire link joining the slave-node assist and the master end.
// Assumes each end drives only low; the wire level is resolved here from the enables.
`timescale 1ns/1ps
interface pwm_link_if;
	logic dev_line_out; // Device pin output value
	logic dev_line_oe_n; // Device output enable, low while driving
	logic mst_line_out; // Master pin output value
	logic mst_line_oe_n; // Master output enable, low while driving
	logic line; // Resolved wire level, pulled up when nobody drives low

	// Wired-AND with pull-up
	assign line = ~((~dev_line_oe_n & ~dev_line_out) | (~mst_line_oe_n & ~mst_line_out));

	// Slave node end
	modport device (
		input line,
		output dev_line_out,
		output dev_line_oe_n
	);

	// Master controller end
	modport master (
		input line,
		output mst_line_out,
		output mst_line_oe_n
	);
endinterface

// ==== pwm_bit_serial_link.sv ====
// Slave-node assist for the single-wire link: break-width timer, free-running sync timer
// with capture and compare, start-condition wake, APB register slave and interrupt.
// Assumes the link is synchronous to core_clk and software times bits through the registers.
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module pwm_bit_serial_link
	import pwm_bit_serial_link_pkg::*;
#(
	parameter int TIMER_W = 16 // Timer width
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	output logic wake,
	pwm_link_if.device link
);
	import pwm_bit_serial_link_pkg::*;

	// Elaboration check on timer width
	if (TIMER_W < 8 || TIMER_W > 16) begin : g_bad_width
		$error("TIMER_W must lie in 8..16");
	end

	localparam logic [2:0] FAST_LAST = 3'(FAST_DIV - 1); // Last fast-divider count
	localparam logic [7:0] LP_LAST = 8'(LP_DIV - 1); // Last low-power divider count
	localparam logic [TIMER_W-1:0] T_ONE = TIMER_W'(1); // Timer increment
	localparam logic [TIMER_W-1:0] T_MAX = '1; // Timer saturation value

	// All state of the block
	typedef struct packed {
		logic [15:0] ctrl; // Sync control register
		logic [3:0] status; // Sticky event flags
		logic [3:0] mask; // Interrupt mask
		logic [TIMER_W-1:0] brk; // Break-width timer
		logic brk_run; // Break timer counting
		logic [TIMER_W-1:0] sync; // Free-running sync timer
		logic [TIMER_W-1:0] cap; // Edge capture value
		logic [TIMER_W-1:0] cmp; // Pulse compare value
		logic drive; // Software asks to pull the line low
		logic line_prev; // Line level last cycle
		logic [2:0] fdiv; // Fast-tick divider
		logic [7:0] ldiv; // Low-power tick divider
		logic [31:0] rdata; // Read data latched in setup phase
		logic wake; // Wake pulse
	} dev_state_s;

	dev_state_s q; // Registered state
	dev_state_s d; // Next state

	logic fall; // Falling edge on the line
	logic rise; // Rising edge on the line
	logic fast_tick; // 5 MHz enable
	logic lp_tick; // Low-power oscillator enable
	logic mode; // Bit-serial mode
	logic [TIMER_W-1:0] sync_next; // Sync timer after increment
	logic [3:0] st_set; // Events this cycle
	logic [3:0] st_clr; // Software clear this cycle
	logic wr_acc; // Write access phase
	logic rd_setup; // Read setup phase
	logic mapped; // Address hits a register

	// Next-state logic
	always_comb begin
		d = q;
		st_set = 4'h0;
		st_clr = 4'h0;
		mode = q.ctrl[CTL_MODE];
		fall = q.line_prev & ~link.line;
		rise = ~q.line_prev & link.line;
		d.line_prev = link.line;
		d.wake = 1'b0;

		// Fast tick divider, always running
		fast_tick = (q.fdiv == FAST_LAST);
		if (fast_tick) begin
			d.fdiv = 3'h0;
		end else begin
			d.fdiv = q.fdiv + 3'h1;
		end

		// Low-power oscillator divider
		lp_tick = (q.ldiv == LP_LAST);
		if (lp_tick) begin
			d.ldiv = 8'h00;
		end else begin
			d.ldiv = q.ldiv + 8'h01;
		end

		// Sync timer runs continuously in mode, held at zero outside it
		sync_next = q.sync + T_ONE;
		if (!mode) begin
			d.sync = TIMER_RESET[TIMER_W-1:0];
		end else if (fast_tick) begin
			d.sync = sync_next;
		end

		// Compare match on the tick that reaches the compare value
		if (mode && fast_tick && sync_next == q.cmp && q.ctrl[CTL_CMP_EN]) begin
			st_set[ST_CMP] = 1'b1;
		end

		// Capture the sync timer on each falling edge
		if (mode && fall) begin
			d.cap = q.sync;
		end

		// Break-width timer: clear on fall, count low-power periods, stop on rise
		if (!mode) begin
			d.brk_run = 1'b0;
		end else if (fall) begin
			d.brk = TIMER_RESET[TIMER_W-1:0];
			d.brk_run = 1'b1;
		end else if (rise && q.brk_run) begin
			d.brk_run = 1'b0;
			if (q.ctrl[CTL_RISE_EN]) begin
				st_set[ST_RISE] = 1'b1;
			end
		end else if (q.brk_run && lp_tick && q.brk != T_MAX) begin
			d.brk = q.brk + T_ONE;
		end

		// Start condition works in any mode so it can wake the core
		if (fall && q.ctrl[CTL_START_EN]) begin
			st_set[ST_START] = 1'b1;
			d.wake = 1'b1;
		end

		// Address decode
		mapped = 1'b1;
		if (paddr == SYNC_CONTROL_OFS) begin
			d.rdata = {16'h0000, q.ctrl};
		end else if (paddr == SYNC_STATUS_OFS) begin
			d.rdata = {28'h0, q.status};
		end else if (paddr == IRQ_MASK_OFS) begin
			d.rdata = {28'h0, q.mask};
		end else if (paddr == BREAK_WIDTH_OFS) begin
			d.rdata = 32'(q.brk);
		end else if (paddr == SYNC_TIMER_OFS) begin
			d.rdata = 32'(q.sync);
		end else if (paddr == EDGE_CAPTURE_OFS) begin
			d.rdata = 32'(q.cap);
		end else if (paddr == PULSE_COMPARE_OFS) begin
			d.rdata = 32'(q.cmp);
		end else if (paddr == LINE_DRIVE_OFS) begin
			d.rdata = {30'h0, link.line, q.drive};
		end else begin
			mapped = 1'b0;
			d.rdata = 32'h0000_0000;
		end
		rd_setup = psel & ~penable & ~pwrite;
		if (!rd_setup) begin
			d.rdata = q.rdata; // Hold through the access phase
		end

		// Register writes take effect in the access phase
		wr_acc = psel & penable & pwrite;
		if (wr_acc) begin
			if (paddr == SYNC_CONTROL_OFS) begin
				d.ctrl = pwdata[15:0];
			end else if (paddr == SYNC_STATUS_OFS) begin
				st_clr = pwdata[3:0]; // Write one to clear
			end else if (paddr == IRQ_MASK_OFS) begin
				d.mask = pwdata[3:0];
			end else if (paddr == PULSE_COMPARE_OFS) begin
				d.cmp = pwdata[TIMER_W-1:0];
			end else if (paddr == LINE_DRIVE_OFS) begin
				d.drive = pwdata[0];
			end
		end

		// A new event wins over a clear in the same cycle
		d.status = (q.status & ~st_clr) | st_set;
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			q <= '{ctrl: CTL_RESET, status: 4'h0, mask: 4'h0, brk: '0, brk_run: 1'b0,
				sync: '0, cap: '0, cmp: '0, drive: 1'b0, line_prev: 1'b1,
				fdiv: 3'h0, ldiv: 8'h00, rdata: 32'h0000_0000, wake: 1'b0};
		end else begin
			q <= d;
		end
	end

	// Bus answers: zero wait states, error on unmapped address
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata = q.rdata;

	// Level interrupt while any unmasked flag stands
	assign irq = |(q.status & q.mask);
	assign wake = q.wake;

	// Open-drain pin: pull low only in bit-serial mode when software asks
	assign link.dev_line_out = 1'b0;
	assign link.dev_line_oe_n = ~(q.drive & mode);
endmodule

// ==== pwm_link_master.sv ====
// Master controller end of the single-wire link: sends whole frames and reads slave bits.
// Assumes the slave answers in the same bit periods that this end opens.
`timescale 1ns/1ps
module pwm_link_master
	import pwm_bit_serial_link_pkg::*;
#(
	parameter int BIT_CYC = BIT_CYCLES // Core cycles per bit period
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic start,
	input wire logic dir,
	input wire logic [2:0] slave_addr,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] wdata,
	output logic busy,
	output logic done,
	output logic [7:0] rdata,
	output logic ack_ok,
	output logic parity_ok,
	pwm_link_if.master link
);
	import pwm_bit_serial_link_pkg::*;

	// Elaboration check on bit period
	if (BIT_CYC < 16 || BIT_CYC > 65535) begin : g_bad_period
		$error("BIT_CYC must lie in 16..65535");
	end

	localparam logic [15:0] LAST_CYC = 16'(BIT_CYC - 1); // Last cycle of a period
	localparam logic [15:0] SYNC_CYC = 16'(BIT_CYC * SYNC_16THS / 16);
	localparam logic [15:0] ZERO_CYC = 16'(BIT_CYC * ZERO_16THS / 16);
	localparam logic [15:0] ONE_CYC = 16'(BIT_CYC * ONE_16THS / 16);
	localparam logic [15:0] SAMPLE_CYC = 16'(BIT_CYC * ZO_MID_16THS / 16);
	localparam logic [4:0] LAST_BIT = 5'(TOTAL_BITS - 1); // Last period index

	typedef enum logic [0:0] {
		M_IDLE = 1'b0, // Waiting for start
		M_FRAME = 1'b1 // Sending a frame
	} mst_state_e;

	// All state of the master
	typedef struct packed {
		mst_state_e st; // Frame state
		logic [4:0] idx; // Period index, pause first
		logic [15:0] cnt; // Cycle within period
		logic [18:0] tx; // Frame bits, first in the MSB
		logic dir; // Direction of this frame
		logic [9:0] rx; // Slave bits: data, parity, ack
		logic rx_bit; // Sampled slave bit this period
		logic done; // Frame finished pulse
		logic [7:0] rdata; // Data read from slave
		logic ack_ok; // Ack was zero
		logic parity_ok; // Data parity matched
	} mst_state_s;

	mst_state_s q; // Registered state
	mst_state_s d; // Next state

	logic [4:0] fi; // Index within the 19-bit frame
	logic pause; // Period belongs to the pause
	logic slave_bit; // Slave sends this period
	logic [15:0] low_len; // Cycles this end holds low
	logic [9:0] rx_all; // Slave bits including this period

	// Next-state logic
	always_comb begin
		d = q;
		d.done = 1'b0;
		fi = q.idx - 5'(PAUSE_BITS);
		pause = (q.idx < 5'(PAUSE_BITS));
		slave_bit = !pause && (fi == 5'(FI_ACK) || (q.dir && fi >= 5'(FI_DATA)));
		// Slave periods get only the opening sync pulse from this end
		if (pause || slave_bit) begin
			low_len = SYNC_CYC;
		end else if (q.tx[18]) begin
			low_len = ONE_CYC;
		end else begin
			low_len = ZERO_CYC;
		end
		rx_all = {q.rx[8:0], q.rx_bit};
		case (q.st)
			M_IDLE: begin
				if (start) begin
					d.st = M_FRAME;
					d.idx = 5'h00;
					d.cnt = 16'h0000;
					d.dir = dir;
					// Parities are one for an odd count of ones
					d.tx = {dir, slave_addr, reg_addr, ^{dir, slave_addr, reg_addr}, wdata,
						^wdata, 1'b0};
					d.rx = 10'h000;
				end
			end
			M_FRAME: begin
				// Slave bit is one if the line is still low midway between zero and one
				if (slave_bit && q.cnt == SAMPLE_CYC) begin
					d.rx_bit = ~link.line;
				end
				if (q.cnt == LAST_CYC) begin
					d.cnt = 16'h0000;
					if (slave_bit) begin
						d.rx = rx_all;
					end
					if (!pause) begin
						d.tx = {q.tx[17:0], 1'b0};
					end
					if (q.idx == LAST_BIT) begin
						d.st = M_IDLE;
						d.done = 1'b1;
						d.ack_ok = ~rx_all[0];
						if (q.dir) begin
							d.rdata = rx_all[9:2];
							d.parity_ok = (^rx_all[9:2]) == rx_all[1];
						end else begin
							d.parity_ok = 1'b1;
						end
					end else begin
						d.idx = q.idx + 5'h01;
					end
				end else begin
					d.cnt = q.cnt + 16'h0001;
				end
			end
			default: begin
				d.st = M_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			q <= '{st: M_IDLE, idx: 5'h00, cnt: 16'h0000, tx: 19'h0, dir: 1'b0, rx: 10'h000,
				rx_bit: 1'b0, done: 1'b0, rdata: 8'h00, ack_ok: 1'b0, parity_ok: 1'b0};
		end else begin
			q <= d;
		end
	end

	// User-side outputs
	assign busy = (q.st == M_FRAME);
	assign done = q.done;
	assign rdata = q.rdata;
	assign ack_ok = q.ack_ok;
	assign parity_ok = q.parity_ok;

	// Pull low from the start of each period for the coded low time
	assign link.mst_line_out = 1'b0;
	assign link.mst_line_oe_n = ~((q.st == M_FRAME) && (q.cnt < low_len));
endmodule

// ==== pwm_link_assertions.sv ====
// Checker for the single-wire link between the slave-node assist and the master end.
// Assumes it sits beside the interface and shares the master's bit period.
`timescale 1ns/1ps
module pwm_link_assertions
	import pwm_bit_serial_link_pkg::*;
#(
	parameter int BIT_CYC = BIT_CYCLES // Core cycles per bit period, as the master end
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic dev_line_out,
	input wire logic dev_line_oe_n,
	input wire logic mst_line_out,
	input wire logic mst_line_oe_n,
	input wire logic line,
	input wire logic wake
);
	import pwm_bit_serial_link_pkg::*;

	localparam int SYNC_LEN = BIT_CYC * 2 / 16; // Master sync pulse
	localparam int ZERO_LEN = BIT_CYC * 6 / 16; // Master zero pulse
	localparam int ONE_LEN = BIT_CYC * 12 / 16; // Master one pulse
	localparam int DEV_MAX = BIT_CYC * 14 / 16; // Longest legal slave pulse
	logic [15:0] mlo_q; // Master low run
	logic [15:0] dlo_q; // Device low run
	logic [15:0] gap_q; // Cycles since last master fall, saturating
	logic mprev_q; // Master enable one cycle ago

	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	// Run-length counters for the pulse checks
	always_ff @(posedge core_clk) begin
		if (rst) begin
			mlo_q <= 16'h0000;
			dlo_q <= 16'h0000;
			gap_q <= 16'hFFFF;
			mprev_q <= 1'b1;
		end else begin
			mlo_q <= mst_line_oe_n ? 16'h0000 : mlo_q + 16'h0001;
			dlo_q <= dev_line_oe_n ? 16'h0000 : dlo_q + 16'h0001;
			gap_q <= (mprev_q & ~mst_line_oe_n) ? 16'h0001 : gap_q + {15'h0000, ~&gap_q};
			mprev_q <= mst_line_oe_n;
		end
	end

	sequence s_open;
		$fell(mst_line_oe_n);
	endsequence
	sequence s_held;
		!mst_line_oe_n [*8];
	endsequence

	property p_drive_low;
		!dev_line_out && !mst_line_out;
	endproperty
	a_drive_low: assert property (p_drive_low)
		else $error("link end drives high");
	property p_mst_width;
		$rose(mst_line_oe_n) |-> mlo_q == SYNC_LEN || mlo_q == ZERO_LEN || mlo_q == ONE_LEN;
	endproperty
	a_mst_width: assert property (p_mst_width)
		else $error("master pulse width wrong");
	property p_mst_hold;
		s_open |-> s_held;
	endproperty
	a_mst_hold: assert property (p_mst_hold)
		else $error("master pulse too short");
	property p_bit_gap;
		s_open |-> gap_q >= BIT_CYC;
	endproperty
	a_bit_gap: assert property (p_bit_gap)
		else $error("bit periods too close");
	property p_line_master_first;
		$fell(line) |-> $fell(mst_line_oe_n);
	endproperty
	a_line_master_first: assert property (p_line_master_first)
		else $error("line fell without master");
	property p_dev_in_sync;
		$fell(dev_line_oe_n) |-> !mst_line_oe_n && mlo_q < SYNC_LEN;
	endproperty
	a_dev_in_sync: assert property (p_dev_in_sync)
		else $error("slave pulled low outside sync time");
	property p_dev_release;
		dlo_q <= DEV_MAX;
	endproperty
	a_dev_release: assert property (p_dev_release)
		else $error("slave held line too long");
	property p_wake_pulse;
		wake |=> !wake;
	endproperty
	a_wake_pulse: assert property (p_wake_pulse)
		else $error("wake longer than one cycle");
	property p_wake_cause;
		wake |-> !$past(line);
	endproperty
	a_wake_cause: assert property (p_wake_cause)
		else $error("wake without low line");
endmodule

// ==== testbench.sv ====
// Self-checking bench: device end and master end joined over the link interface.
// Assumes software-timed slave bits through the APB registers of the device end.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin errors++; \
	$display("FAIL %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
	import pwm_bit_serial_link_pkg::*;
	localparam int BC = 1520; // Bit period: sync, zero, one span 1, 3, 6 break ticks
	localparam int LO[3] = '{1, 5, 10}; // Shortest sync, zero, one in sixteenths
	localparam int HI[3] = '{3, 8, 14}; // Longest sync, zero, one in sixteenths
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready, pslverr, irq, wake, busy, done, ack_ok, parity_ok;
	logic start = 1'b0;
	logic dir = 1'b0;
	logic [2:0] slave_addr = 3'h0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic [31:0] r; // Last read data
	logic perr; // Last slave error
	int errors = 0;
	int comparisons = 0;
	int cycles = 0;
	int lcnt = 0; // Current low run on the wire
	int lw[$]; // Low runs seen on the wire

	pwm_link_if pwm_link_if_i ();
	pwm_bit_serial_link pwm_bit_serial_link_i (.core_clk(core_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .wake(wake), .link(pwm_link_if_i.device));
	pwm_link_master #(.BIT_CYC(BC)) pwm_link_master_i (.core_clk(core_clk), .rst(rst),
		.start(start), .dir(dir), .slave_addr(slave_addr), .reg_addr(reg_addr), .wdata(wdata),
		.busy(busy), .done(done), .rdata(rdata), .ack_ok(ack_ok), .parity_ok(parity_ok),
		.link(pwm_link_if_i.master));
	pwm_link_assertions #(.BIT_CYC(BC)) pwm_link_assertions_i (.core_clk(core_clk), .rst(rst),
		.dev_line_out(pwm_link_if_i.dev_line_out), .dev_line_oe_n(pwm_link_if_i.dev_line_oe_n),
		.mst_line_out(pwm_link_if_i.mst_line_out), .mst_line_oe_n(pwm_link_if_i.mst_line_oe_n),
		.line(pwm_link_if_i.line), .wake(wake));

	// 25 MHz clock
	always #20 core_clk = ~core_clk;

	// Record every low run on the wire
	always @(posedge core_clk) begin
		if (pwm_link_if_i.line === 1'b0) begin
			lcnt++;
		end else if (lcnt != 0) begin
			lw.push_back(lcnt);
			lcnt = 0;
		end
	end

	// Hang guard
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 95000) begin
			errors++;
			give_verdict();
		end
	end

	task automatic give_verdict;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// One APB transfer; held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		r = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask

	// Wait for wake (0), irq (1) or done (2)
	task automatic wait_on(input int sel);
		do @(negedge core_clk); while ((sel == 0 ? wake : sel == 1 ? irq : done) !== 1'b1);
		@(posedge core_clk);
	endtask

	function automatic logic ok_len(int len, int lo, int hi);
		return len >= BC * lo / 16 && len <= BC * hi / 16;
	endfunction

	task automatic test_regs;
		apb(1'b0, SYNC_CONTROL_OFS, 32'h0);
		`CHK("ctrl_reset", 32'h0, r)
		apb(1'b0, SYNC_TIMER_OFS, 32'h0);
		`CHK("timer_off_mode", 32'h0, r)
		apb(1'b1, LINE_DRIVE_OFS, 32'h1);
		repeat (2) @(posedge core_clk);
		`CHK("drive_off_mode", 1'b1, pwm_link_if_i.dev_line_oe_n)
		apb(1'b1, LINE_DRIVE_OFS, 32'h0);
		apb(1'b1, 8'h20, 32'hFFFF);
		`CHK("unmapped_err", 1'b1, perr)
		apb(1'b1, EDGE_CAPTURE_OFS, 32'h1234);
		apb(1'b0, EDGE_CAPTURE_OFS, 32'h0);
		`CHK("capture_ro", 32'h0, r)
		apb(1'b1, PULSE_COMPARE_OFS, 32'hA5A5);
		apb(1'b0, PULSE_COMPARE_OFS, 32'h0);
		`CHK("compare_rw", 32'hA5A5, r)
	endtask

	// Reads 50 cycles apart are 10 fast ticks apart
	task automatic test_timer;
		logic [31:0] t_first;
		apb(1'b1, SYNC_CONTROL_OFS, 32'h40);
		apb(1'b0, SYNC_TIMER_OFS, 32'h0);
		t_first = r;
		repeat (47) @(posedge core_clk);
		apb(1'b0, SYNC_TIMER_OFS, 32'h0);
		`CHK("timer_step", t_first + 32'd10, r)
	endtask

	// Compare match sets a sticky status bit; mask gates irq; writing one clears
	task automatic test_compare;
		apb(1'b1, SYNC_CONTROL_OFS, 32'h60);
		apb(1'b1, IRQ_MASK_OFS, 32'h0);
		apb(1'b0, SYNC_TIMER_OFS, 32'h0);
		apb(1'b1, PULSE_COMPARE_OFS, r + 32'd20);
		repeat (150) @(posedge core_clk);
		apb(1'b0, SYNC_STATUS_OFS, 32'h0);
		`CHK("cmp_status", 32'h8, r)
		`CHK("irq_masked", 1'b0, irq)
		apb(1'b1, IRQ_MASK_OFS, 32'h8);
		@(posedge core_clk);
		`CHK("irq_unmasked", 1'b1, irq)
		apb(1'b1, SYNC_STATUS_OFS, 32'h8);
		@(posedge core_clk);
		`CHK("irq_cleared", 1'b0, irq)
	endtask

	// Slave bit: pull low, time the width with capture plus compare, release
	task automatic send_bit(input logic b);
		apb(1'b1, LINE_DRIVE_OFS, 32'h1);
		apb(1'b0, EDGE_CAPTURE_OFS, 32'h0);
		apb(1'b1, PULSE_COMPARE_OFS,
			r + 32'(BC * (b ? ONE_16THS : ZERO_16THS) / 16 / FAST_DIV));
		wait_on(1);
		apb(1'b1, LINE_DRIVE_OFS, 32'h0);
	endtask

	// Whole frame; device decodes master bits from the break timer
	task automatic run_frame(input logic d, input logic [7:0] dat, input logic ak);
		logic [18:0] fb;
		int i;
		int j;
		fb = {d, 3'h5, 4'hA, ^{d, 3'h5, 4'hA}, dat, ^dat, ak};
		lw.delete();
		apb(1'b1, SYNC_CONTROL_OFS, 32'h168);
		apb(1'b1, IRQ_MASK_OFS, 32'h9);
		start <= 1'b1;
		dir <= d;
		slave_addr <= 3'h5;
		reg_addr <= 4'hA;
		wdata <= dat;
		@(posedge core_clk);
		start <= 1'b0;
		for (int k = 0; k < TOTAL_BITS; k++) begin
			i = k - PAUSE_BITS;
			wait_on(0);
			`CHK("busy", 1'b1, busy)
			apb(1'b1, SYNC_STATUS_OFS, 32'hB);
			if (i == FI_ACK || (d && i >= FI_DATA)) begin
				send_bit(fb[18 - i]);
			end else begin
				wait_on(1);
				apb(1'b0, BREAK_WIDTH_OFS, 32'h0);
				if (i >= 0) `CHK("break_bit", fb[18 - i], r >= 32'd5)
			end
		end
		wait_on(2);
		`CHK("idle", 1'b0, busy)
		`CHK("ack", ~ak, ack_ok)
		`CHK("parity", 1'b1, parity_ok)
		if (d) `CHK("read_data", dat, rdata)
		`CHK("periods", TOTAL_BITS, lw.size())
		foreach (lw[k]) begin
			j = (k < PAUSE_BITS) ? 0 : (fb[18 + PAUSE_BITS - k] ? 2 : 1);
			`CHK("wire_len", 1'b1, ok_len(lw[k], LO[j], HI[j]))
		end
	endtask

	initial begin
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		test_regs();
		test_timer();
		test_compare();
		run_frame(1'b0, 8'hC3, 1'b0);
		run_frame(1'b1, 8'h96, 1'b1);
		give_verdict();
	end
endmodule
